// ---- shared/sdram_pkg.sv ----
// Constants, command codes and carriers for the synchronous DRAM command block.
// Assumes a single 200 MHz clock shared with the memory controller driving the pins.
//
// Notes on behaviour
// RQ1 - Commands, addresses, masks and write data are sampled only on the rising clock edge.
// RQ2 - Clock gate sampled low freezes all internal state from the next edge.
// RQ3 - Controller raises clock gate at least one cycle before a new command.
// RQ4 - With chip select high, command and address are ignored; masks stay live.
// RQ5 - Twelve row bits taken at activate, eight column bits at read or write.
// RQ6 - Two bank bits select bank A, B, C or D for every bank command.
// RQ7 - Precharge with auto-precharge bit high closes all four banks.
// RQ8 - Mode set only with all banks idle; next command two cycles later.
// RQ9 - Refresh or self-refresh entry only with every bank precharged.
// RQ10 - No new read or write during an auto-precharge burst.
// RQ11 - Burst stop ends the running burst for every burst length.
// RQ12 - Mask blocks write data same cycle; floats read data two cycles later.
// RQ13 - Burst length codes 1, 2, 4, 8 and full page of 256; rest reserved.
// RQ14 - Mode bit 3 picks sequential or interleaved; full page sequential only.
// RQ15 - Mode set loads mode from pins; latency codes 2 and 3; test bits 00.
// RQ16 - Counter makes later columns: sequential wraps in block, interleave uses XOR.
// RQ17 - Controller holds gate and mask high with no-ops for 200us at power-up.
// RQ18 - Controller then precharges all banks.
// RQ19 - Controller issues two or more refreshes; mode set before or after.
// RQ20 - Controller writes reserved mode bits as zero.
// RQ21 - Controller refreshes all rows within 64ms using 4K refreshes.
// RQ22 - Four banks of 1,048,576 sixteen-bit words on a two-way data bus.
// RQ23 - Auto-precharge bit high on read or write closes that bank after the burst.
// RQ24 - Refresh with clock gate low enters self-refresh; outputs float meanwhile.
// RQ25 - Command decode from chip select, row, column and write strobes.
// RQ26 - Read data appears the programmed latency after the command, one word per cycle.

package sdram_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int ROW_W  = 12;
  localparam int COL_W  = 8;
  localparam int BANK_W = 2;
  localparam int DATA_W = 16;
  localparam int MODE_W = 14;
  localparam int AP_BIT = 10;

  // ****************************************************************
  // Mode register encodings and reset value
  // ****************************************************************
  localparam logic [2:0]        BL_1       = 3'h0;
  localparam logic [2:0]        BL_2       = 3'h1;
  localparam logic [2:0]        BL_4       = 3'h2;
  localparam logic [2:0]        BL_8       = 3'h3;
  localparam logic [2:0]        BL_PAGE    = 3'h7;
  localparam logic [2:0]        CL_2       = 3'h2;
  localparam logic [2:0]        CL_3       = 3'h3;
  localparam logic              ORDER_SEQ  = 1'b0;
  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0000;
  localparam logic              CKE_RESET  = 1'b0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MSET, CMD_REF, CMD_ACT, CMD_PRE, CMD_READ, CMD_WRITE, CMD_BST
  } cmd_e;

  typedef struct packed {
    logic chip_select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_enable_n;
  } cmd_pins_s;

  typedef struct packed {
    logic [1:0] rsv_bank;
    logic [1:0] rsv_high;
    logic       rsv_a9;
    logic [1:0] test_mode;
    logic [2:0] latency;
    logic       burst_type_bit;
    logic [2:0] burst_len;
  } mode_s;

endpackage

// ---- logic/sdram_array.sv ----
// Byte-writable storage array with registered read data.
// Assumes one access per cycle; read data hold until the next read or fully masked write.
`timescale 1ns/1ps

module sdram_array #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Access port
  input  wire logic                en,
  input  wire logic [DATA_W/8-1:0] we,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   wdata,
  output logic      [DATA_W-1:0]   rdata
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ****************************************************************
  // Write with per-byte enables
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    for (int b = 0; b < DATA_W/8; b++) begin
      if (en && we[b]) begin
        mem[addr][b*8 +: 8] <= wdata[b*8 +: 8];
      end
    end
  end

  // ****************************************************************
  // Registered read, loaded on a read or a fully masked write, held otherwise
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else if (en && we == '0) begin
      rdata <= mem[addr];
    end
  end

endmodule

// ---- logic/sdram_command_interface.sv ----
// Command decoder, bank state, burst engine and data path of the DRAM.
// Assumes the controller shares sys_clk, so pins are sampled without synchronisers.
`timescale 1ns/1ps

module sdram_command_interface #(
  parameter int ROW_W  = sdram_pkg::ROW_W,
  parameter int COL_W  = sdram_pkg::COL_W,
  parameter int BANK_W = sdram_pkg::BANK_W,
  parameter int DATA_W = sdram_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rstn,
  // Command pins
  input  wire logic                    clk_gate,
  input  wire sdram_pkg::cmd_pins_s    cmd_pins,
  input  wire logic [ROW_W-1:0]        addr,
  input  wire logic [BANK_W-1:0]       bank_select_bits,
  // Byte masks
  input  wire logic                    low_byte_mask,
  input  wire logic                    high_byte_mask,
  // Two-way data bus
  input  wire logic [DATA_W-1:0]       data_in,
  output logic      [DATA_W-1:0]       data_out,
  output logic      [DATA_W/8-1:0]     data_oe_n
);

  localparam int NBANK  = 1 << BANK_W;
  localparam int ADDR_W = BANK_W + ROW_W + COL_W;
  localparam int NBYTE  = DATA_W / 8;

  // ****************************************************************
  // Clock gate and command decode
  // ****************************************************************
  logic                   cke_prev_r;
  logic                   self_ref_r;
  logic                   active;
  sdram_pkg::cmd_e        cmd;
  logic [NBYTE-1:0]       mask_pins;

  assign active    = cke_prev_r && !self_ref_r; // [RQ2]
  assign mask_pins = {high_byte_mask, low_byte_mask};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cke_prev_r <= sdram_pkg::CKE_RESET;
    end else begin
      cke_prev_r <= clk_gate; // [RQ1] [RQ2]
    end
  end

  always_comb begin
    cmd = sdram_pkg::CMD_NOP;
    // Chip select high leaves only masks and clock gate effective
    if (active && !cmd_pins.chip_select_n) begin // [RQ4]
      case ({cmd_pins.row_strobe_n, cmd_pins.col_strobe_n, cmd_pins.write_enable_n}) // [RQ25]
        3'h0:    cmd = sdram_pkg::CMD_MSET;
        3'h1:    cmd = sdram_pkg::CMD_REF;
        3'h3:    cmd = sdram_pkg::CMD_ACT;
        3'h2:    cmd = sdram_pkg::CMD_PRE;
        3'h5:    cmd = sdram_pkg::CMD_READ;
        3'h4:    cmd = sdram_pkg::CMD_WRITE;
        3'h6:    cmd = sdram_pkg::CMD_BST;
        default: cmd = sdram_pkg::CMD_NOP;
      endcase
    end
  end

  // ****************************************************************
  // Self-refresh
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      self_ref_r <= 1'b0;
    end else if (cmd == sdram_pkg::CMD_REF && !clk_gate) begin
      self_ref_r <= 1'b1; // [RQ24]
    end else if (self_ref_r && clk_gate) begin
      self_ref_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Mode register
  // ****************************************************************
  sdram_pkg::mode_s       mode_r;
  logic [COL_W-1:0]       len_mask;
  logic                   lat3;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= sdram_pkg::MODE_RESET;
    end else if (cmd == sdram_pkg::CMD_MSET) begin
      mode_r <= {bank_select_bits, addr}; // [RQ15]
    end
  end

  // Reserved codes fall back to a single-beat burst
  always_comb begin
    case (mode_r.burst_len) // [RQ13]
      sdram_pkg::BL_1:    len_mask = '0;
      sdram_pkg::BL_2:    len_mask = COL_W'(1);
      sdram_pkg::BL_4:    len_mask = COL_W'(3);
      sdram_pkg::BL_8:    len_mask = COL_W'(7);
      sdram_pkg::BL_PAGE: len_mask = (mode_r.burst_type_bit == sdram_pkg::ORDER_SEQ) ? '1 : '0; // [RQ14]
      default:            len_mask = '0;
    endcase
  end

  // Reserved latency codes behave as latency 3
  assign lat3 = (mode_r.latency != sdram_pkg::CL_2); // [RQ15]

  // ****************************************************************
  // Burst engine
  // ****************************************************************
  logic                   burst_r;
  logic                   wr_r;
  logic                   ilv_r;
  logic                   ap_r;
  logic [BANK_W-1:0]      bank_r;
  logic [COL_W-1:0]       start_r;
  logic [COL_W-1:0]       beat_r;
  logic [COL_W-1:0]       blk_r;
  logic                   col_cmd;
  logic                   step;
  logic                   last_beat;
  logic                   finish;
  logic [BANK_W-1:0]      finish_bank;
  logic [COL_W-1:0]       seq_col;
  logic [COL_W-1:0]       ilv_col;

  assign col_cmd   = (cmd == sdram_pkg::CMD_READ) || (cmd == sdram_pkg::CMD_WRITE);
  assign step      = active && burst_r && !col_cmd && cmd != sdram_pkg::CMD_BST;
  assign last_beat = (beat_r == blk_r);
  assign seq_col   = (start_r & ~blk_r) | (COL_W'(start_r + beat_r) & blk_r); // [RQ16]
  assign ilv_col   = (start_r & ~blk_r) | ((start_r ^ beat_r) & blk_r); // [RQ16]

  // Auto-precharge closes the bank once the last beat is served
  always_comb begin
    finish      = 1'b0;
    finish_bank = bank_r;
    if (col_cmd && len_mask == '0 && addr[sdram_pkg::AP_BIT]) begin
      finish      = 1'b1;
      finish_bank = bank_select_bits;
    end else if (step && last_beat && ap_r) begin
      finish = 1'b1; // [RQ23]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      burst_r <= 1'b0;
      wr_r    <= 1'b0;
      ilv_r   <= 1'b0;
      ap_r    <= 1'b0;
      bank_r  <= '0;
      start_r <= '0;
      beat_r  <= '0;
      blk_r   <= '0;
    end else if (col_cmd) begin
      burst_r <= (len_mask != '0);
      wr_r    <= (cmd == sdram_pkg::CMD_WRITE);
      ilv_r   <= mode_r.burst_type_bit;
      ap_r    <= addr[sdram_pkg::AP_BIT];
      bank_r  <= bank_select_bits; // [RQ6]
      start_r <= addr[COL_W-1:0]; // [RQ5]
      beat_r  <= COL_W'(1);
      blk_r   <= len_mask;
    end else if (cmd == sdram_pkg::CMD_BST) begin
      burst_r <= 1'b0; // [RQ11]
    end else if (step) begin
      burst_r <= !last_beat;
      beat_r  <= COL_W'(beat_r + COL_W'(1));
    end
  end

  // ****************************************************************
  // Bank state
  // ****************************************************************
  logic [NBANK-1:0]       open_r;
  logic [ROW_W-1:0]       row_r [NBANK];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      open_r <= '0;
    end else begin
      // Close first, so an activate or precharge elsewhere never hides it
      if (finish) begin
        open_r[finish_bank] <= 1'b0; // [RQ23]
      end
      if (cmd == sdram_pkg::CMD_ACT) begin
        open_r[bank_select_bits] <= 1'b1; // [RQ6]
      end else if (cmd == sdram_pkg::CMD_PRE) begin
        if (addr[sdram_pkg::AP_BIT]) begin
          open_r <= '0; // [RQ7]
        end else begin
          open_r[bank_select_bits] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NBANK; i++) begin
        row_r[i] <= '0;
      end
    end else if (cmd == sdram_pkg::CMD_ACT) begin
      row_r[bank_select_bits] <= addr; // [RQ5]
    end
  end

  // ****************************************************************
  // Array access
  // ****************************************************************
  logic                   mem_en;
  logic [NBYTE-1:0]       mem_we;
  logic [ADDR_W-1:0]      mem_addr;
  logic [DATA_W-1:0]      mem_rdata;
  logic                   rd_issue;
  logic                   wr_issue;
  logic [BANK_W-1:0]      acc_bank;
  logic [COL_W-1:0]       acc_col;

  assign rd_issue = (cmd == sdram_pkg::CMD_READ) || (step && !wr_r);
  assign wr_issue = (cmd == sdram_pkg::CMD_WRITE) || (step && wr_r);
  assign acc_bank = col_cmd ? bank_select_bits : bank_r;
  assign acc_col  = col_cmd ? addr[COL_W-1:0] : (ilv_r ? ilv_col : seq_col);
  assign mem_en   = rd_issue || wr_issue;
  assign mem_we   = wr_issue ? ~mask_pins : '0; // [RQ12]
  assign mem_addr = {acc_bank, row_r[acc_bank], acc_col};

  // Default geometry gives four banks of 2**20 words
  sdram_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_array ( // [RQ22]
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .en      (mem_en),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (data_in),
    .rdata   (mem_rdata)
  );

  // ****************************************************************
  // Read pipeline and output drivers
  // ****************************************************************
  logic                   rvalid0_r;
  logic                   rvalid1_r;
  logic [DATA_W-1:0]      pipe1_r;
  logic [NBYTE-1:0]       mask_r;
  logic                   out_valid;

  assign out_valid = lat3 ? rvalid1_r : rvalid0_r;

  // Frozen clock holds the whole pipeline, so a suspended read resumes intact
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid0_r <= 1'b0;
      rvalid1_r <= 1'b0;
      pipe1_r   <= '0;
      mask_r    <= '1;
    end else if (cke_prev_r) begin
      rvalid0_r <= rd_issue;
      rvalid1_r <= rvalid0_r;
      pipe1_r   <= mem_rdata;
      mask_r    <= mask_pins; // [RQ12]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      data_out  <= '0;
      data_oe_n <= '1;
    end else if (self_ref_r) begin
      data_oe_n <= '1; // [RQ24]
    end else if (cke_prev_r) begin
      data_out  <= lat3 ? pipe1_r : mem_rdata; // [RQ26]
      data_oe_n <= out_valid ? mask_r : '1; // [RQ12]
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_read_lat2;
    cmd == sdram_pkg::CMD_READ && !lat3 && clk_gate && !low_byte_mask ##1 clk_gate;
  endsequence

  sequence s_read_lat3;
    cmd == sdram_pkg::CMD_READ && lat3 && clk_gate ##1 clk_gate && !low_byte_mask ##1 clk_gate;
  endsequence

  a_freeze_hold: assert property (!cke_prev_r |=> $stable(beat_r) && $stable(open_r) && $stable(mode_r)) // [RQ2]
    else $error("state changed while clock gate was low");

  a_cs_ignore: assert property (cmd_pins.chip_select_n |-> cmd == sdram_pkg::CMD_NOP) // [RQ4]
    else $error("command decoded with chip select high");

  a_precharge_all: assert property (cmd == sdram_pkg::CMD_PRE && addr[sdram_pkg::AP_BIT] |=> open_r == '0) // [RQ7]
    else $error("precharge all left a bank open");

  a_mode_load: assert property (cmd == sdram_pkg::CMD_MSET |=> mode_r == $past({bank_select_bits, addr})) // [RQ15]
    else $error("mode register not loaded from pins");

  a_read_lat2: assert property (s_read_lat2 |=> !data_oe_n[0] && $past(mem_rdata) == data_out) // [RQ26]
    else $error("latency 2 read data not driven");

  a_read_lat3: assert property (s_read_lat3 |=> !data_oe_n[0]) // [RQ26]
    else $error("latency 3 read data not driven");

  a_read_mask: assert property (out_valid && cke_prev_r && !self_ref_r && mask_r[1] |=> data_oe_n[1]) // [RQ12]
    else $error("masked read byte was driven");

  a_write_mask: assert property (wr_issue && low_byte_mask |-> !mem_we[0]) // [RQ12]
    else $error("masked write byte reached the array");

  a_burst_stop: assert property (cmd == sdram_pkg::CMD_BST |=> !burst_r) // [RQ11]
    else $error("burst kept running after burst stop");

  a_seq_wrap: assert property (step && !ilv_r && beat_r == blk_r |-> // [RQ16]
    (acc_col & blk_r) == ((start_r - COL_W'(1)) & blk_r))
    else $error("sequential burst did not wrap in its block");

  a_auto_close: assert property (step && last_beat && ap_r |=> !open_r[$past(bank_r)]) // [RQ23]
    else $error("auto-precharge bank still open after burst");

  a_self_float: assert property (cmd == sdram_pkg::CMD_REF && !clk_gate |=> self_ref_r ##1 &data_oe_n) // [RQ24]
    else $error("outputs driven in self-refresh");

endmodule

// ---- verif/host_model.sv ----
// Host controller model: drives the DRAM pins and logs every driven read word.
// Assumes one shared sys_clk; pins change only just after a rising edge.
`timescale 1ns/1ps

module host_model #(
  parameter int PWR_WAIT = 40000
) (
  // Clock
  input  wire logic            sys_clk,
  // Command side
  output logic                 clk_gate,
  output sdram_pkg::cmd_pins_s cmd_pins,
  output logic [11:0]          addr,
  output logic [1:0]           bank_select_bits,
  output logic                 low_byte_mask,
  output logic                 high_byte_mask,
  // Data bus halves
  output logic [15:0]          data_in,
  input  wire logic [15:0]     data_out,
  input  wire logic [1:0]      data_oe_n
);
  int          cyc    = 0;
  int          at     = 0;
  logic        gate   = 1'b1;
  logic        cs_off = 1'b0;
  logic        drv    = 1'b0;
  logic [15:0] hd     = 16'h0000;
  logic [15:0] last   = 16'h0000;
  logic [49:0] rq[$];

  // No pull on the bus, so a released byte must not keep a usable level
  for (genvar i = 0; i < 2; i++) begin : g_lane
    assign data_in[8*i+:8] = !data_oe_n[i] ? data_out[8*i+:8] : drv ? hd[8*i+:8] : ~last[8*i+:8];
  end

  initial begin
    clk_gate         = 1'b1;
    cmd_pins         = 4'h7;
    addr             = 12'h000;
    bank_select_bits = 2'h0;
    low_byte_mask    = 1'b1;
    high_byte_mask   = 1'b1;
  end

  always @(posedge sys_clk) begin
    cyc  <= cyc + 1;
    last <= data_in;
    if (data_oe_n !== 2'b11)
      rq.push_back({cyc, data_oe_n, data_out});
  end

  // ****************************************
  // Command issue
  // ****************************************
  function automatic logic [2:0] enc(input sdram_pkg::cmd_e c);
    case (c)
      sdram_pkg::CMD_MSET:  return 3'h0;
      sdram_pkg::CMD_REF:   return 3'h1;
      sdram_pkg::CMD_PRE:   return 3'h2;
      sdram_pkg::CMD_ACT:   return 3'h3;
      sdram_pkg::CMD_WRITE: return 3'h4;
      sdram_pkg::CMD_READ:  return 3'h5;
      sdram_pkg::CMD_BST:   return 3'h6;
      default:              return 3'h7;
    endcase
  endfunction

  task automatic cmd(input sdram_pkg::cmd_e c, input logic [1:0] b, input logic [11:0] a,
                     input logic [1:0] m, input logic den, input logic [15:0] d);
    @(posedge sys_clk);
    clk_gate         <= gate;
    cmd_pins         <= {cs_off, enc(c)};
    addr             <= a;
    bank_select_bits <= b;
    high_byte_mask   <= m[1];
    low_byte_mask    <= m[0];
    drv              <= den;
    hd               <= d;
    at = cyc + 1;
  endtask

  task automatic idle(input int n);
    repeat (n) cmd(sdram_pkg::CMD_NOP, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
  endtask

  // Banks closed first, reserved bits forced low
  task automatic mode_set(input logic [6:0] mode);
    cmd(sdram_pkg::CMD_PRE, 2'h0, 12'h400, 2'h0, 1'b0, 16'h0000);
    cmd(sdram_pkg::CMD_MSET, 2'h0, {5'h00, mode}, 2'h0, 1'b0, 16'h0000);
    idle(2);
  endtask

  // Run is far shorter than one refresh period, so no periodic refresh
  task automatic power_up(input logic [6:0] mode);
    repeat (PWR_WAIT) @(posedge sys_clk);
    cmd(sdram_pkg::CMD_PRE, 2'h0, 12'h400, 2'h3, 1'b0, 16'h0000);
    repeat (2) cmd(sdram_pkg::CMD_REF, 2'h0, 12'h000, 2'h3, 1'b0, 16'h0000);
    mode_set(mode);
  endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the DRAM command block, driven through the host model.
// Assumes the host model logs each driven read word with its cycle stamp.
`timescale 1ns/1ps

module tb;
  logic                 sys_clk = 1'b0;
  logic                 rstn    = 1'b0;
  logic                 clk_gate;
  sdram_pkg::cmd_pins_s cmd_pins;
  logic [11:0]          addr;
  logic [1:0]           bank_select_bits;
  logic                 low_byte_mask;
  logic                 high_byte_mask;
  logic [15:0]          data_in;
  logic [15:0]          data_out;
  logic [1:0]           data_oe_n;
  int                   n_fail    = 0;
  int                   tests_run = 0;
  int                   ticks     = 0;
  int                   bl        = 1;
  int                   cl        = 3;
  logic                 bt        = 1'b0;
  logic                 desel     = 1'b0;
  logic [11:0]          row_of [4];
  logic [15:0]          shadow [logic [21:0]];

  sdram_command_interface sdram_command_interface_i (
    .sys_clk(sys_clk), .rstn(rstn), .clk_gate(clk_gate), .cmd_pins(cmd_pins), .addr(addr),
    .bank_select_bits(bank_select_bits), .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  host_model host_model_i (
    .sys_clk(sys_clk), .clk_gate(clk_gate), .cmd_pins(cmd_pins), .addr(addr),
    .bank_select_bits(bank_select_bits), .low_byte_mask(low_byte_mask), .high_byte_mask(high_byte_mask),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  initial forever #2.5 sys_clk = ~sys_clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [7:0] col_at(input logic [7:0] s, input int i);
    logic [7:0] m;
    m = 8'(bl - 1);
    return bt ? s ^ 8'(i) : (s & ~m) | ((s + 8'(i)) & m);
  endfunction

  task automatic set_mode(input logic [2:0] blc, input logic t, input logic [2:0] clc);
    bt = t;
    cl = (clc == sdram_pkg::CL_2) ? 2 : 3;
    case (blc)
      sdram_pkg::BL_2:    bl = 2;
      sdram_pkg::BL_4:    bl = 4;
      sdram_pkg::BL_8:    bl = 8;
      sdram_pkg::BL_PAGE: bl = t ? 1 : 256;
      default:            bl = 1;
    endcase
    host_model_i.mode_set({clc, t, blc});
  endtask

  task automatic act(input logic [1:0] b, input logic [11:0] r);
    row_of[b] = r;
    host_model_i.cmd(sdram_pkg::CMD_ACT, b, r, 2'h0, 1'b0, 16'h0000);
  endtask

  task automatic wr(input logic [1:0] b, input logic [7:0] c, input int n, input int mi,
                    input logic [1:0] mk, input logic [15:0] base);
    logic [15:0] d;
    logic [15:0] k;
    logic [21:0] key;
    for (int i = 0; i < n; i++) begin
      d = base + 16'(i) * 16'h0101;
      k = (i == mi) ? ~{{8{mk[1]}}, {8{mk[0]}}} : 16'hffff;
      key = {b, row_of[b], col_at(c, i)};
      shadow[key] = (shadow[key] & ~k) | (d & k);
      host_model_i.cmd(i == 0 ? sdram_pkg::CMD_WRITE : sdram_pkg::CMD_NOP, b, {4'h0, c},
                       (i == mi) ? mk : 2'h0, 1'b1, d);
    end
    host_model_i.cmd(sdram_pkg::CMD_BST, b, 12'h000, 2'h0, 1'b0, 16'h0000);
  endtask

  // Reads n words (burst stop after n when n is short); word mi gets mask mk
  task automatic rd(input logic [1:0] b, input logic [7:0] c, input logic ap, input int n,
                    input int mi, input logic [1:0] mk);
    int          t;
    logic [49:0] e;
    logic [15:0] k;
    host_model_i.rq.delete();
    for (int s = 0; s < cl + bl + 2; s++) begin
      host_model_i.cs_off = desel && s > 0;
      host_model_i.cmd(s == 0 ? sdram_pkg::CMD_READ : (s == n && n < bl) ? sdram_pkg::CMD_BST
                       : sdram_pkg::CMD_NOP, b, {1'b0, ap, 2'h0, c}, (s == cl + mi - 2) ? mk : 2'h0,
                       1'b0, 16'h0000);
    end
    host_model_i.cs_off = 1'b0;
    #1;
    t = host_model_i.at - cl - bl - 1;
    chk(host_model_i.rq.size(), n);
    for (int i = 0; i < host_model_i.rq.size(); i++) begin
      e = host_model_i.rq[i];
      k = (i == mi) ? ~{{8{mk[1]}}, {8{mk[0]}}} : 16'hffff;
      chk(e[49:18], t + cl + i);
      chk(e[17:16], (i == mi) ? mk : 2'h0);
      chk(e[15:0] & k, shadow[{b, row_of[b], col_at(c, i)}] & k);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_banks();
    set_mode(sdram_pkg::BL_4, 1'b0, sdram_pkg::CL_2);
    for (int b = 0; b < 4; b++) begin
      act(2'(b), 12'hfff - 12'(b));
      wr(2'(b), 8'h01, 4, -1, 2'h0, 16'h1000 * 16'(b + 1));
    end
    for (int b = 0; b < 4; b++)
      rd(2'(b), 8'h01, b == 3, 4, -1, 2'h0);
  endtask

  task automatic t_codes();
    for (int m = 0; m < 20; m++) begin
      set_mode(3'(m % 5), 1'(m / 10), ((m / 5) % 2) ? sdram_pkg::CL_3 : sdram_pkg::CL_2);
      act(2'h2, 12'h0a5);
      wr(2'h2, 8'h35, bl, -1, 2'h0, 16'(m) << 8);
      rd(2'h2, 8'h35, 1'b0, bl, -1, 2'h0);
      rd(2'h2, 8'h35, 1'b0, (bl + 1) / 2, -1, 2'h0);
    end
  endtask

  task automatic t_page();
    set_mode(sdram_pkg::BL_PAGE, 1'b0, sdram_pkg::CL_3);
    act(2'h3, 12'h123);
    wr(2'h3, 8'hfe, 256, -1, 2'h0, 16'h4000);
    rd(2'h3, 8'hfc, 1'b0, 9, -1, 2'h0);
    set_mode(sdram_pkg::BL_PAGE, 1'b1, sdram_pkg::CL_2);
    act(2'h3, 12'h123);
    wr(2'h3, 8'h10, 1, -1, 2'h0, 16'h5a5a);
    rd(2'h3, 8'h10, 1'b0, 1, -1, 2'h0);
  endtask

  task automatic t_mask();
    set_mode(sdram_pkg::BL_4, 1'b0, sdram_pkg::CL_2);
    act(2'h0, 12'h300);
    wr(2'h0, 8'h08, 4, -1, 2'h0, 16'h1111);
    wr(2'h0, 8'h08, 4, 2, 2'h2, 16'h7700);
    rd(2'h0, 8'h08, 1'b0, 4, 1, 2'h1);
    desel = 1'b1;
    rd(2'h0, 8'h08, 1'b0, 4, 3, 2'h2);
    desel = 1'b0;
    host_model_i.cs_off = 1'b1;
    host_model_i.cmd(sdram_pkg::CMD_WRITE, 2'h0, 12'h008, 2'h0, 1'b1, 16'hdead);
    host_model_i.cs_off = 1'b0;
    rd(2'h0, 8'h08, 1'b0, 4, -1, 2'h0);
  endtask

  // Deliberately presents a write on the frozen edge, then parks in self-refresh
  task automatic t_gate();
    host_model_i.gate = 1'b0;
    host_model_i.idle(1);
    host_model_i.gate = 1'b1;
    host_model_i.cmd(sdram_pkg::CMD_WRITE, 2'h0, 12'h008, 2'h0, 1'b1, 16'hbeef);
    rd(2'h0, 8'h08, 1'b0, 4, -1, 2'h0);
    host_model_i.cmd(sdram_pkg::CMD_PRE, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
    host_model_i.gate = 1'b0;
    host_model_i.cmd(sdram_pkg::CMD_REF, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
    host_model_i.rq.delete();
    repeat (4) host_model_i.cmd(sdram_pkg::CMD_READ, 2'h0, 12'h008, 2'h0, 1'b0, 16'h0000);
    host_model_i.gate = 1'b1;
    host_model_i.idle(2);
    #1;
    chk(host_model_i.rq.size(), 0);
    act(2'h0, 12'h300);
    rd(2'h0, 8'h08, 1'b0, 4, -1, 2'h0);
  endtask

  // Ceiling sits well above power-up wait plus all scenarios
  always @(posedge sys_clk) begin
    ticks <= ticks + 1;
    if (ticks == 60000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    host_model_i.power_up({sdram_pkg::CL_2, sdram_pkg::ORDER_SEQ, sdram_pkg::BL_4});
    t_banks();
    t_codes();
    t_page();
    t_mask();
    t_gate();
    final_report();
  end
endmodule
